// ### rtl/mie_exec_core.sv
// Instruction execution sequencer for the call-to-move group of the core
// Operation
// - Call pushes the next address on the stack and loads the target on the same edge.
// - Call takes two instruction cycles.
// - Byte clear writes zero to memory, flags untouched.
// - Bit clear zeroes only the chosen bit, other bits and flags kept.
// - Watchdog clear resets the counter and clears timeout and power-down flags.
// - In-place invert writes the complement back and updates the zero flag.
// - Invert to work register leaves memory alone and updates the zero flag.
// - Decimal fixup adds 6 to low nibble if above 9 or half carry.
// - Decimal fixup adds 6 to high nibble if above 9 or carry.
// - Decimal fixup result goes to data memory, not the work register.
// - Decimal fixup may change only the carry flag, marking sums above 99.
// - In-place count down stores the byte minus one and updates zero.
// - Count down to work register, memory unchanged, zero updated.
// - Sleep halts execution and stops the clock, keeping all contents.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep sets the power-down flag and clears the timeout flag.
// - In-place count up stores the byte plus one and updates zero.
// - Count up to work register, memory unchanged, zero updated.
// - Branch loads the target and takes two cycles with a dummy cycle.
// - Copy loads the work register from memory or immediate, no flags.
// - Copy stores the work register to memory, no flags.
`timescale 1ns/1ps
`default_nettype none
module mie_exec_core
  import mie_pkg::*;
#(
  parameter int PC_W = MIE_PC_W,
  parameter int DA_W = MIE_DA_W
)(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire mie_op_t i_op,
  input wire logic [PC_W-1:0] i_target,
  input wire logic [DA_W-1:0] i_dm_index,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_imm,
  input wire logic [7:0] i_dm_rdata,
  input wire logic i_flag_load,
  input wire logic i_half_carry_flag_in,
  input wire logic i_ripple_flag_in,
  input wire logic i_wdt_timeout,
  input wire logic i_wake,
  output logic o_ready,
  output logic [PC_W-1:0] o_pc,
  output logic [PC_W-1:0] o_stack_top,
  output logic [DA_W-1:0] o_dm_addr,
  output logic o_dm_re,
  output logic o_dm_we,
  output logic [7:0] o_dm_wdata,
  output logic [7:0] o_work_register,
  output logic o_zero_flag,
  output logic o_ripple_flag,
  output logic o_half_carry_flag,
  output logic o_watchdog_timeout_flag,
  output logic o_power_down_flag,
  output logic o_wdt_clear,
  output logic o_prescaler_clear,
  output logic o_sleep
);

  typedef struct packed {
    mie_state_t state;
    mie_op_t op;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] pc;
    logic [DA_W-1:0] dm_addr;
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic [7:0] work;
    logic zf;
    logic cf;
    logic acf;
    logic tof;
    logic pwr_dn;
    logic dm_re;
    logic dm_we;
    logic [7:0] dm_wdata;
    logic wdt_clr;
    logic presc_clr;
    logic sleep;
    logic ready;
  } mie_core_st_t;

  localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);

  mie_core_st_t core_r;
  mie_core_st_t core_nxt;
  logic stk_push;

  mie_alu_if alu_bus ();

  mie_alu u_alu (
    .a (alu_bus.alu)
  );

  mie_ret_stack #(
    .W (PC_W),
    .DEPTH (MIE_STACK_DEPTH)
  ) u_stack (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_ce (i_ce),
    .i_push (stk_push),
    .i_push_val (core_r.pc + PC_ONE),
    .o_top (o_stack_top)
  );

  // Memory read data is only meaningful in the execute state
  // The data memory does not see the enable, and the read enable is high only in the read state, not in execute
  assign alu_bus.op = core_r.op;
  assign alu_bus.operand = i_dm_rdata;
  assign alu_bus.work = core_r.work;
  assign alu_bus.imm = core_r.imm;
  assign alu_bus.bit_sel = core_r.bit_sel;
  assign alu_bus.acf = core_r.acf;
  assign alu_bus.cf = core_r.cf;

  always_comb
  begin
    core_nxt = core_r;
    core_nxt.dm_re = 1'b0;
    core_nxt.dm_we = 1'b0;
    core_nxt.wdt_clr = 1'b0;
    core_nxt.presc_clr = 1'b0;
    stk_push = 1'b0;
    // Flags produced by arithmetic outside this group load only while idle
    if (i_flag_load && (core_r.state == ST_IDLE))
    begin
      core_nxt.acf = i_half_carry_flag_in;
      core_nxt.cf = i_ripple_flag_in;
    end
    case (core_r.state)
      ST_IDLE:
      begin
        if (i_instr_valid)
        begin
          core_nxt.op = i_op;
          core_nxt.target = i_target;
          core_nxt.dm_addr = i_dm_index;
          core_nxt.bit_sel = i_bit_sel;
          core_nxt.imm = i_imm;
          core_nxt.dm_re = 1'b1;
          core_nxt.ready = 1'b0;
          core_nxt.state = ST_READ;
        end
      end
      ST_READ:
      begin
        core_nxt.state = ST_EXEC;
      end
      ST_EXEC:
      begin
        core_nxt.pc = core_r.pc + PC_ONE;
        core_nxt.state = ST_IDLE;
        core_nxt.ready = 1'b1;
        if (alu_bus.wr_mem)
        begin
          core_nxt.dm_we = 1'b1;
          core_nxt.dm_wdata = alu_bus.result;
        end
        if (alu_bus.wr_acc)
          core_nxt.work = alu_bus.result;
        if (alu_bus.upd_zero)
          core_nxt.zf = alu_bus.zero;
        if (alu_bus.upd_carry)
          core_nxt.cf = alu_bus.carry;
        case (core_r.op)
          OP_CALL:
          begin
            stk_push = 1'b1;
            core_nxt.pc = core_r.target;
            core_nxt.state = ST_DUMMY;
            core_nxt.ready = 1'b0;
          end
          OP_BRANCH:
          begin
            core_nxt.pc = core_r.target;
            core_nxt.state = ST_DUMMY;
            core_nxt.ready = 1'b0;
          end
          OP_CLRWDT:
          begin
            core_nxt.wdt_clr = 1'b1;
            core_nxt.tof = 1'b0;
            core_nxt.pwr_dn = 1'b0;
          end
          OP_SLEEP:
          begin
            core_nxt.wdt_clr = 1'b1;
            core_nxt.presc_clr = 1'b1;
            core_nxt.pwr_dn = 1'b1;
            core_nxt.tof = 1'b0;
            core_nxt.sleep = 1'b1;
            core_nxt.state = ST_SLEEP;
            core_nxt.ready = 1'b0;
          end
          default:
          begin
          end
        endcase
      end
      ST_DUMMY:
      begin
        core_nxt.state = ST_IDLE;
        core_nxt.ready = 1'b1;
      end
      ST_SLEEP:
      begin
        // Nothing but the timeout flag is touched while asleep, so all other contents survive
        if (i_wake)
        begin
          core_nxt.sleep = 1'b0;
          core_nxt.state = ST_IDLE;
          core_nxt.ready = 1'b1;
        end
      end
      default:
      begin
        core_nxt.state = ST_IDLE;
        core_nxt.ready = 1'b1;
      end
    endcase
    // A timeout in the same cycle as a clear must not be lost
    if (i_wdt_timeout)
      core_nxt.tof = 1'b1;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rstn == MIE_RST_LOW)
    begin
      core_r <= '0;
      core_r.state <= ST_IDLE;
      core_r.op <= OP_NOP;
      core_r.ready <= 1'b1;
    end
    else if (i_ce)
      core_r <= core_nxt;
  end

  assign o_ready = core_r.ready;
  assign o_pc = core_r.pc;
  assign o_dm_addr = core_r.dm_addr;
  assign o_dm_re = core_r.dm_re;
  assign o_dm_we = core_r.dm_we;
  assign o_dm_wdata = core_r.dm_wdata;
  assign o_work_register = core_r.work;
  assign o_zero_flag = core_r.zf;
  assign o_ripple_flag = core_r.cf;
  assign o_half_carry_flag = core_r.acf;
  assign o_watchdog_timeout_flag = core_r.tof;
  assign o_power_down_flag = core_r.pwr_dn;
  assign o_wdt_clear = core_r.wdt_clr;
  assign o_prescaler_clear = core_r.presc_clr;
  assign o_sleep = core_r.sleep;

  // Checks: every relation except the sleep-hold and dummy-end ones is taken from an execute edge with the enable high
  logic ex_go;
  assign ex_go = (core_r.state == ST_EXEC) && i_ce;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rstn == MIE_RST_LOW);

  AST_CALL_PUSH: assert property (ex_go && core_r.op == OP_CALL |=>
    o_stack_top == $past(core_r.pc) + PC_ONE && o_pc == $past(core_r.target))
    else $error("call did not push next address or load target");
  AST_CALL_TWO: assert property (ex_go && core_r.op == OP_CALL |=>
    core_r.state == ST_DUMMY && !o_ready)
    else $error("call did not take its extra cycle");
  AST_ZERO_WR: assert property (ex_go && core_r.op == OP_ZERO |=>
    o_dm_we && o_dm_wdata == MIE_BYTE_CLEAR && $stable(o_zero_flag) && $stable(o_ripple_flag))
    else $error("byte clear wrote wrong value or touched flags");
  AST_BITCLR: assert property (ex_go && core_r.op == OP_BITCLR |=>
    o_dm_we && o_dm_wdata == ($past(i_dm_rdata) & ~(MIE_BIT_ONE << $past(core_r.bit_sel))))
    else $error("bit clear changed the wrong bits");
  AST_CLRWDT: assert property (ex_go && core_r.op == OP_CLRWDT && !i_wdt_timeout |=>
    o_wdt_clear && !o_watchdog_timeout_flag && !o_power_down_flag ##1 !o_wdt_clear)
    else $error("watchdog clear effects wrong");
  AST_INV_MEM: assert property (ex_go && core_r.op == OP_INV_MEM |=>
    o_dm_we && o_dm_wdata == ~$past(i_dm_rdata) && o_zero_flag == ($past(i_dm_rdata) == 8'hff))
    else $error("in-place invert wrong");
  AST_INV_ACC: assert property (ex_go && core_r.op == OP_INV_ACC |=>
    !o_dm_we && o_work_register == ~$past(i_dm_rdata))
    else $error("invert to work register wrong");
  AST_BCD_DEST: assert property (ex_go && core_r.op == OP_BCD |=>
    o_dm_we && $stable(o_work_register) && $stable(o_zero_flag))
    else $error("decimal fixup wrote wrong place or touched zero flag");
  AST_BCD_CARRY: assert property (ex_go && core_r.op == OP_BCD && core_r.cf |=>
    o_ripple_flag)
    else $error("decimal fixup cleared the carry");
  AST_DEC_ACC: assert property (ex_go && core_r.op == OP_DEC_ACC |=>
    !o_dm_we && o_work_register == $past(i_dm_rdata) - MIE_STEP_ONE)
    else $error("count down to work register wrong");
  AST_INC_MEM: assert property (ex_go && core_r.op == OP_INC_MEM |=>
    o_dm_we && o_dm_wdata == $past(i_dm_rdata) + MIE_STEP_ONE)
    else $error("in-place count up wrong");
  AST_SLEEP: assert property (ex_go && core_r.op == OP_SLEEP && !i_wdt_timeout |=>
    o_sleep && o_power_down_flag && !o_watchdog_timeout_flag && o_wdt_clear && o_prescaler_clear)
    else $error("sleep entry effects wrong");
  AST_SLEEP_HOLD: assert property (core_r.state == ST_SLEEP && !i_wake |=>
    $stable(o_work_register) && $stable(o_pc) && o_sleep && !o_ready)
    else $error("state changed while asleep");
  AST_BRANCH: assert property (ex_go && core_r.op == OP_BRANCH |=>
    o_pc == $past(core_r.target) && !o_ready)
    else $error("branch target or timing wrong");
  AST_MOV_IMM: assert property (ex_go && core_r.op == OP_MOV_A_X |=>
    o_work_register == $past(core_r.imm) && !o_dm_we && $stable(o_zero_flag))
    else $error("immediate copy wrong");
  AST_MOV_LOAD: assert property (ex_go && core_r.op == OP_MOV_A_M |=>
    !o_dm_we && o_work_register == $past(i_dm_rdata) && $stable(o_zero_flag))
    else $error("memory copy to work register wrong");
  AST_MOV_STORE: assert property (ex_go && core_r.op == OP_MOV_M_A |=>
    o_dm_we && o_dm_wdata == $past(core_r.work) && $stable(o_zero_flag) && $stable(o_ripple_flag))
    else $error("store of work register wrong or flags touched");
  AST_DEC_MEM: assert property (ex_go && core_r.op == OP_DEC_MEM |=>
    o_dm_we && o_dm_wdata == $past(i_dm_rdata) - MIE_STEP_ONE && o_zero_flag == !(|o_dm_wdata))
    else $error("in-place count down wrong");
  AST_INC_ACC: assert property (ex_go && core_r.op == OP_INC_ACC |=>
    !o_dm_we && o_work_register == $past(i_dm_rdata) + MIE_STEP_ONE)
    else $error("count up to work register wrong");
  AST_BITCLR_FLAGS: assert property (ex_go && core_r.op == OP_BITCLR |=>
    $stable(o_zero_flag) && $stable(o_ripple_flag) && $stable(o_work_register))
    else $error("bit clear touched flags or work register");
  AST_BCD_LOW: assert property (ex_go && core_r.op == OP_BCD && !core_r.acf &&
    core_r.work[3:0] <= MIE_BCD_MAX |=> o_dm_wdata[3:0] == $past(core_r.work[3:0]))
    else $error("decimal fixup changed a valid low digit");
  AST_BCD_SET: assert property (ex_go && core_r.op == OP_BCD |=>
    (o_dm_wdata - $past(core_r.work)) inside {8'h00, 8'h06, 8'h60, 8'h66})
    else $error("decimal fixup correction outside the four allowed values");
  AST_DUMMY_END: assert property (core_r.state == ST_DUMMY && i_ce |=>
    o_ready && core_r.state == ST_IDLE && $stable(o_pc))
    else $error("dummy cycle did not end after one cycle");

  COV_CALL: cover property (ex_go && core_r.op == OP_CALL);
  COV_BCD_CARRY: cover property (ex_go && core_r.op == OP_BCD && alu_bus.carry && !core_r.cf);
  COV_SLEEP_WAKE: cover property (core_r.state == ST_SLEEP && i_wake && i_ce);
  COV_TO_RACE: cover property (ex_go && core_r.op == OP_CLRWDT && i_wdt_timeout);

endmodule : mie_exec_core
`default_nettype wire

// ### rtl/mie_pkg.sv
// Shared constants, opcodes and state codes for the instruction execution block
package mie_pkg;

  localparam int MIE_PC_W = 10;
  localparam int MIE_DA_W = 5;
  localparam int MIE_STACK_DEPTH = 2;
  localparam logic MIE_RST_LOW = 1'b0;
  localparam logic MIE_RST_HIGH = 1'b1;
  localparam logic [7:0] MIE_BYTE_CLEAR = 8'h00;
  localparam logic [7:0] MIE_BIT_ONE = 8'h01;
  localparam logic [7:0] MIE_STEP_ONE = 8'h01;
  localparam logic [3:0] MIE_BCD_MAX = 4'h9;
  localparam logic [3:0] MIE_BCD_FIX = 4'h6;
  localparam logic [3:0] MIE_NIB_NONE = 4'h0;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_CALL = 5'h01,
    OP_BRANCH = 5'h02,
    OP_ZERO = 5'h03,
    OP_BITCLR = 5'h04,
    OP_CLRWDT = 5'h05,
    OP_INV_MEM = 5'h06,
    OP_INV_ACC = 5'h07,
    OP_BCD = 5'h08,
    OP_DEC_MEM = 5'h09,
    OP_DEC_ACC = 5'h0a,
    OP_SLEEP = 5'h0b,
    OP_INC_MEM = 5'h0c,
    OP_INC_ACC = 5'h0d,
    OP_MOV_A_M = 5'h0e,
    OP_MOV_A_X = 5'h0f,
    OP_MOV_M_A = 5'h10
  } mie_op_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_READ = 5'b00010,
    ST_EXEC = 5'b00100,
    ST_DUMMY = 5'b01000,
    ST_SLEEP = 5'b10000
  } mie_state_t;

endpackage : mie_pkg

// ### rtl/mie_alu_if.sv
// Operand and result bundle between the sequencer and the datapath
`timescale 1ns/1ps
`default_nettype none
interface mie_alu_if;
  import mie_pkg::*;
  mie_op_t op;
  logic [7:0] operand;
  logic [7:0] work;
  logic [7:0] imm;
  logic [2:0] bit_sel;
  logic acf;
  logic cf;
  logic [7:0] result;
  logic zero;
  logic carry;
  logic wr_mem;
  logic wr_acc;
  logic upd_zero;
  logic upd_carry;
  modport core (output op, operand, work, imm, bit_sel, acf, cf,
                input result, zero, carry, wr_mem, wr_acc, upd_zero, upd_carry);
  modport alu (input op, operand, work, imm, bit_sel, acf, cf,
               output result, zero, carry, wr_mem, wr_acc, upd_zero, upd_carry);
endinterface : mie_alu_if
`default_nettype wire

// ### rtl/mie_alu.sv
// Combinational datapath: result, destination and flag effects per opcode
`timescale 1ns/1ps
`default_nettype none
module mie_alu
  import mie_pkg::*;
(
  mie_alu_if.alu a
);
  logic [7:0] res;
  logic [7:0] corr;
  logic [8:0] sum9;

  always_comb
  begin
    res = a.operand;
    corr = MIE_BYTE_CLEAR;
    sum9 = '0;
    a.wr_mem = 1'b0;
    a.wr_acc = 1'b0;
    a.upd_zero = 1'b0;
    a.upd_carry = 1'b0;
    a.carry = a.cf;
    case (a.op)
      OP_ZERO: begin res = MIE_BYTE_CLEAR; a.wr_mem = 1'b1; end
      OP_BITCLR: begin res = a.operand & ~(MIE_BIT_ONE << a.bit_sel); a.wr_mem = 1'b1; end
      OP_INV_MEM: begin res = ~a.operand; a.wr_mem = 1'b1; a.upd_zero = 1'b1; end
      OP_INV_ACC: begin res = ~a.operand; a.wr_acc = 1'b1; a.upd_zero = 1'b1; end
      OP_BCD:
      begin
        corr[3:0] = ((a.work[3:0] > MIE_BCD_MAX) || a.acf) ? MIE_BCD_FIX : MIE_NIB_NONE;
        corr[7:4] = ((a.work[7:4] > MIE_BCD_MAX) || a.cf) ? MIE_BCD_FIX : MIE_NIB_NONE;
        sum9 = {1'b0, a.work} + {1'b0, corr};
        res = sum9[7:0];
        a.wr_mem = 1'b1;
        a.upd_carry = 1'b1;
        a.carry = sum9[8] | a.cf;
      end
      OP_DEC_MEM: begin res = a.operand - MIE_STEP_ONE; a.wr_mem = 1'b1; a.upd_zero = 1'b1; end
      OP_DEC_ACC: begin res = a.operand - MIE_STEP_ONE; a.wr_acc = 1'b1; a.upd_zero = 1'b1; end
      OP_INC_MEM: begin res = a.operand + MIE_STEP_ONE; a.wr_mem = 1'b1; a.upd_zero = 1'b1; end
      OP_INC_ACC: begin res = a.operand + MIE_STEP_ONE; a.wr_acc = 1'b1; a.upd_zero = 1'b1; end
      OP_MOV_A_M: begin res = a.operand; a.wr_acc = 1'b1; end
      OP_MOV_A_X: begin res = a.imm; a.wr_acc = 1'b1; end
      OP_MOV_M_A: begin res = a.work; a.wr_mem = 1'b1; end
      default: res = a.operand;
    endcase
    a.result = res;
    a.zero = (res == MIE_BYTE_CLEAR);
  end
endmodule : mie_alu
`default_nettype wire

// ### rtl/mie_ret_stack.sv
// Return address stack; a push beyond the depth drops the oldest entry
`timescale 1ns/1ps
`default_nettype none
module mie_ret_stack
  import mie_pkg::*;
#(
  parameter int W = MIE_PC_W,
  parameter int DEPTH = MIE_STACK_DEPTH
)(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_push,
  input wire logic [W-1:0] i_push_val,
  output logic [W-1:0] o_top
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
  } mie_stk_st_t;

  mie_stk_st_t stk_r;
  mie_stk_st_t stk_nxt;

  always_comb
  begin
    stk_nxt = stk_r;
    if (i_push)
    begin
      for (int k = DEPTH - 1; k > 0; k--)
      begin
        stk_nxt.ent[k] = stk_r.ent[k-1];
      end
      stk_nxt.ent[0] = i_push_val;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rstn == MIE_RST_LOW)
      stk_r <= '0;
    else if (i_ce)
      stk_r <= stk_nxt;
  end

  assign o_top = stk_r.ent[0];
endmodule : mie_ret_stack
`default_nettype wire

// ### tb/mie_dmem_model.sv
// Synchronous data memory model standing behind the execution block
`timescale 1ns/1ps
`default_nettype none
module mie_dmem_model
  import mie_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [MIE_DA_W-1:0] i_dm_addr,
  input wire logic i_dm_re,
  input wire logic i_dm_we,
  input wire logic [7:0] i_dm_wdata,
  output logic [7:0] o_dm_rdata
);
  logic [7:0] mem [2**MIE_DA_W];
  initial
  begin
    o_dm_rdata = 8'h00;
    foreach (mem[i])
      mem[i] = 8'h00;
  end
  // Outside a read cycle the bus toggles, so stale data never passes for valid
  always @(posedge i_mclk)
  begin
    o_dm_rdata <= i_dm_re ? mem[i_dm_addr] : ~o_dm_rdata;
    if (i_dm_we)
      mem[i_dm_addr] <= i_dm_wdata;
  end
endmodule : mie_dmem_model
`default_nettype wire

// ### tb/mie_exec_core_tb_top.sv
// Self-checking testbench for the call-to-move execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(16'(g), 16'(e))
`define MEM u_mie_dmem_model.mem
module mie_exec_core_tb_top;
  import mie_pkg::*;
  logic i_mclk, i_rstn, i_ce, i_instr_valid, i_flag_load, i_wdt_timeout, i_wake;
  logic i_half_carry_flag_in, i_ripple_flag_in;
  mie_op_t i_op;
  logic [9:0] i_target, o_pc, o_stack_top, pc0;
  logic [4:0] i_dm_index, o_dm_addr;
  logic [2:0] i_bit_sel;
  logic [7:0] i_imm, i_dm_rdata, o_dm_wdata, o_work_register;
  logic o_ready, o_dm_re, o_dm_we, o_zero_flag, o_ripple_flag, o_half_carry_flag;
  logic o_watchdog_timeout_flag, o_power_down_flag, o_wdt_clear, o_prescaler_clear, o_sleep;
  int fails = 0, n_tests = 0, n_wc = 0, n_pc = 0, n, n0, w0, p0;
  // Decimal fixup cases: work value, result, {half carry, carry in, carry out, 0}
  logic [19:0] bcd_tab [6] = '{20'h12120, 20'h1b210, 20'h13198, 20'ha2022, 20'h35956,
    20'h99ffe};

  mie_exec_core u_mie_exec_core (.i_mclk, .i_rstn, .i_ce, .i_instr_valid, .i_op,
    .i_target, .i_dm_index, .i_bit_sel, .i_imm, .i_dm_rdata, .i_flag_load,
    .i_half_carry_flag_in, .i_ripple_flag_in, .i_wdt_timeout, .i_wake, .o_ready,
    .o_pc, .o_stack_top, .o_dm_addr, .o_dm_re, .o_dm_we, .o_dm_wdata,
    .o_work_register, .o_zero_flag, .o_ripple_flag, .o_half_carry_flag,
    .o_watchdog_timeout_flag, .o_power_down_flag, .o_wdt_clear, .o_prescaler_clear,
    .o_sleep);
  mie_dmem_model u_mie_dmem_model (.i_mclk(i_mclk), .i_dm_addr(o_dm_addr),
    .i_dm_re(o_dm_re), .i_dm_we(o_dm_we), .i_dm_wdata(o_dm_wdata),
    .o_dm_rdata(i_dm_rdata));

  initial
  begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // Pulse counters, so one-cycle strobes are seen in their own cycle
  always @(posedge i_mclk)
  begin
    if (o_wdt_clear === 1'b1)
      n_wc++;
    if (o_prescaler_clear === 1'b1)
      n_pc++;
  end

  task automatic check_val(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask : check_val

  task automatic step;
    @(posedge i_mclk);
    #1;
  endtask : step

  // Presents one request and counts edges until the block is idle again
  task automatic run(input mie_op_t op, input logic [4:0] idx, input int lim = 12);
    i_op = op;
    i_dm_index = idx;
    i_instr_valid = 1'b1;
    n = 0;
    do
    begin
      step();
      i_instr_valid = 1'b0;
      n++;
    end while (o_ready !== 1'b1 && n < lim);
  endtask : run

  task automatic setf(input logic ac, input logic c);
    i_half_carry_flag_in = ac;
    i_ripple_flag_in = c;
    i_flag_load = 1'b1;
    step();
    i_flag_load = 1'b0;
  endtask : setf

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  initial
  begin
    #150000;
    fails++;
    finish_test();
  end

  initial
  begin
    {i_rstn, i_instr_valid, i_flag_load, i_wdt_timeout, i_wake} = '0;
    {i_half_carry_flag_in, i_ripple_flag_in} = '0;
    i_ce = 1'b1;
    i_op = OP_NOP;
    i_target = 10'h000;
    i_dm_index = 5'h00;
    i_bit_sel = 3'h0;
    i_imm = 8'h00;
    repeat (3) @(posedge i_mclk);
    #1;
    i_rstn = 1'b1;
    run(OP_NOP, 5'h00);
    n0 = n;
    i_imm = 8'h5a;
    run(OP_MOV_A_X, 5'h00);
    `CHK(o_work_register, 8'h5a);
    // With the enable low a request must not be taken
    i_ce = 1'b0;
    i_imm = 8'h11;
    run(OP_MOV_A_X, 5'h00);
    `CHK(o_work_register, 8'h5a);
    `CHK(o_dm_re, 1'b0);
    i_ce = 1'b1;
    run(OP_MOV_M_A, 5'h03);
    step();
    `CHK(`MEM[3], 8'h5a);
    `MEM[4] = 8'hc3;
    run(OP_MOV_A_M, 5'h04);
    `CHK(o_work_register, 8'hc3);
    `MEM[6] = 8'hff;
    run(OP_INC_MEM, 5'h06);
    step();
    `CHK(`MEM[6], 8'h00);
    `CHK(o_zero_flag, 1'b1);
    `MEM[5] = 8'h7f;
    run(OP_INC_ACC, 5'h05);
    step();
    `CHK(o_work_register, 8'h80);
    `CHK(o_zero_flag, 1'b0);
    `CHK(`MEM[5], 8'h7f);
    run(OP_ZERO, 5'h04);
    step();
    `CHK(`MEM[4], 8'h00);
    `CHK(o_zero_flag, 1'b0);
    for (int b = 0; b < 8; b++)
    begin
      `MEM[7] = 8'hff;
      i_bit_sel = 3'(b);
      run(OP_BITCLR, 5'h07);
      step();
      `CHK(`MEM[7], 8'(~(8'h01 << b)));
    end
    `MEM[8] = 8'hff;
    run(OP_INV_MEM, 5'h08);
    step();
    `CHK(`MEM[8], 8'h00);
    `CHK(o_zero_flag, 1'b1);
    `MEM[9] = 8'h0f;
    run(OP_INV_ACC, 5'h09);
    step();
    `CHK(o_work_register, 8'hf0);
    `CHK(o_zero_flag, 1'b0);
    `CHK(`MEM[9], 8'h0f);
    `MEM[10] = 8'h01;
    run(OP_DEC_MEM, 5'h0a);
    step();
    `CHK(`MEM[10], 8'h00);
    `CHK(o_zero_flag, 1'b1);
    `MEM[11] = 8'h00;
    run(OP_DEC_ACC, 5'h0b);
    step();
    `CHK(o_work_register, 8'hff);
    `CHK(o_zero_flag, 1'b0);
    `CHK(`MEM[11], 8'h00);
    foreach (bcd_tab[k])
    begin
      i_imm = bcd_tab[k][19:12];
      run(OP_MOV_A_X, 5'h00);
      setf(bcd_tab[k][3], bcd_tab[k][2]);
      run(OP_BCD, 5'h0c);
      step();
      `CHK(`MEM[12], bcd_tab[k][11:4]);
      `CHK(o_work_register, bcd_tab[k][19:12]);
      `CHK(o_ripple_flag, bcd_tab[k][1]);
      `CHK(o_half_carry_flag, bcd_tab[k][3]);
      `CHK(o_zero_flag, 1'b0);
    end
    pc0 = o_pc;
    i_target = 10'h2a5;
    run(OP_CALL, 5'h00);
    `CHK(n, n0 + 1);
    `CHK(o_pc, 10'h2a5);
    `CHK(o_stack_top, pc0 + 10'h001);
    i_target = 10'h031;
    run(OP_CALL, 5'h00);
    `CHK(o_stack_top, 10'h2a6);
    i_target = 10'h155;
    run(OP_BRANCH, 5'h00);
    `CHK(n, n0 + 1);
    `CHK(o_pc, 10'h155);
    `CHK(o_stack_top, 10'h2a6);
    i_wdt_timeout = 1'b1;
    step();
    i_wdt_timeout = 1'b0;
    w0 = n_wc;
    p0 = n_pc;
    run(OP_SLEEP, 5'h00, 6);
    `CHK(o_sleep, 1'b1);
    `CHK(o_power_down_flag, 1'b1);
    `CHK(o_watchdog_timeout_flag, 1'b0);
    `CHK(n_wc - w0, 1);
    `CHK(n_pc - p0, 1);
    // While asleep a request must change nothing
    i_imm = 8'h00;
    i_op = OP_MOV_A_X;
    i_instr_valid = 1'b1;
    repeat (3) step();
    i_instr_valid = 1'b0;
    `CHK(o_ready, 1'b0);
    `CHK(o_work_register, 8'h99);
    `CHK(`MEM[12], 8'hff);
    i_wake = 1'b1;
    step();
    i_wake = 1'b0;
    for (int k = 0; k < 4 && o_ready !== 1'b1; k++)
      step();
    i_wdt_timeout = 1'b1;
    step();
    i_wdt_timeout = 1'b0;
    w0 = n_wc;
    run(OP_CLRWDT, 5'h00);
    step();
    `CHK(o_watchdog_timeout_flag, 1'b0);
    `CHK(o_power_down_flag, 1'b0);
    `CHK(n_wc - w0, 1);
    finish_test();
  end
endmodule : mie_exec_core_tb_top
`default_nettype wire
